// *** hw/timer16_capture_irq_flags_consts.vh ***
// constants for the 16-bit timer capture register and its interrupt mask and flag bits
// assumes an 8-bit register port on a 20 MHz clock, counter and compare logic outside
// Behaviour
// - capture pin or comparator event copies the counter into the capture register.
// - capture register can serve as counter top value per waveform mode.
// - 16-bit capture reads are atomic through a shared 8-bit high-byte temp.
// - capture enable plus global enable requests capture vector while flag is set.
// - match A enable plus global enable requests match A vector while flag is set.
// - match B enable plus global enable requests match B vector while flag is set.
// - wrap enable plus global enable requests wrap vector while flag is set.
// - capture flag sets on each capture event from the pin.
// - when capture register is top, capture flag sets on reaching top.
// - capture flag clears on vector execution or software writing one.
// - match A flag sets the timer cycle after counter equals compare A.
// - forced match A strobe never sets the match A flag.
// - match A flag clears on vector execution or writing one.
// - match B flag sets the timer cycle after counter equals compare B.
// - forced match B strobe never sets the match B flag.
// - match B flag clears on vector execution or writing one.
// - wrap flag sets on overflow in normal and clear modes, else per mode.
// - wrap flag clears on vector execution or writing one.
// - capture pin is disconnected while capture register is top value.
`ifndef TIMER16_CAPTURE_IRQ_FLAGS_CONSTS_VH
`define TIMER16_CAPTURE_IRQ_FLAGS_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_CAPTURE_LOW  3'h0
`define ADDR_CAPTURE_HIGH 3'h1
`define ADDR_IRQ_MASK     3'h2
`define ADDR_IRQ_FLAGS    3'h3
`define ADDR_TEMP_HIGH    3'h4

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BIT_CAPTURE       5
`define BIT_MATCH_A       4
`define BIT_MATCH_B       3
`define BIT_WRAP          2
`define TIMER_BITS_MASK   8'h3C
`define CAPTURE_RESET     16'h0000
`define BYTE_RESET        8'h00

// ----------------------------------------------------------------
// waveform modes and counter limits
// ----------------------------------------------------------------
`define MODE_NORMAL       4'h0
`define MODE_PC8          4'h1
`define MODE_PC9          4'h2
`define MODE_PC10         4'h3
`define MODE_CLEAR_A      4'h4
`define MODE_FAST8        4'h5
`define MODE_FAST9        4'h6
`define MODE_FAST10       4'h7
`define MODE_PFC_CAPTURE  4'h8
`define MODE_PFC_A        4'h9
`define MODE_PC_CAPTURE   4'hA
`define MODE_PC_A         4'hB
`define MODE_CLEAR_CAP    4'hC
`define MODE_FAST_CAPTURE 4'hE
`define MODE_FAST_A       4'hF
`define COUNT_MAX         16'hFFFF
`define COUNT_BOTTOM      16'h0000
`define TOP_8BIT          16'h00FF
`define TOP_9BIT          16'h01FF
`define TOP_10BIT         16'h03FF

`endif

// *** hw/timer16_capture_irq_flags.v ***
// capture register and timer-1 interrupt mask/flag bits of the 16-bit timer
// assumes counter, compare registers and waveform mode come from the timer core on CLK
`timescale 1ns/100ps
`include "timer16_capture_irq_flags_consts.vh"

module timer16_capture_irq_flags (
	// clock and reset
	input  wire        CLK,
	input  wire        RST_B,
	// register port
	input  wire [2:0]  ADDR,
	input  wire [7:0]  WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [7:0]  RDATA,
	// timer core state
	input  wire [15:0] WIDE_COUNTER,
	input  wire        TIMER_TICK,
	input  wire [3:0]  WAVEFORM_MODE_FIELD,
	input  wire [15:0] COMPARE_VALUE_A,
	input  wire [15:0] COMPARE_VALUE_B,
	input  wire        COUNTER_WRITE,
	input  wire        FORCE_MATCH_A_STROBE,
	input  wire        FORCE_MATCH_B_STROBE,
	input  wire        CAPTURE_EDGE_RISING,
	input  wire        CAPTURE_FROM_COMPARATOR,
	// event sources
	input  wire        CAPTURE_INPUT_PIN,
	input  wire        COMPARATOR_OUT,
	// interrupt controller
	input  wire        GLOBAL_IRQ_ENABLE,
	input  wire        ACK_CAPTURE,
	input  wire        ACK_MATCH_A,
	input  wire        ACK_MATCH_B,
	input  wire        ACK_WRAP,
	output wire        IRQ_CAPTURE,
	output wire        IRQ_MATCH_A,
	output wire        IRQ_MATCH_B,
	output wire        IRQ_WRAP,
	// top value to the counter
	output wire [15:0] COUNTER_TOP,
	output wire        CAPTURE_IS_TOP
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg  [15:0] capture_value;
	reg  [7:0]  temp_high;
	reg  [7:0]  timer_irq_enable_mask;
	reg  [7:0]  timer_irq_flags;
	reg  [2:0]  pin_sync;
	reg  [2:0]  cmp_sync;
	reg         pin_level;
	reg         cmp_level;
	reg         match_a_seen;
	reg         match_b_seen;
	reg         count_prev_valid;
	reg  [15:0] count_prev;
	reg  [7:0]  next_flags;
	reg  [15:0] next_capture;
	reg  [15:0] top_value;

	wire        cap_top_mode;
	wire        src_level;
	wire        src_new;
	wire        src_prev;
	wire        capture_event;
	wire        reached_top;
	wire        wrap_event;
	wire [7:0]  flag_set;
	wire [7:0]  flag_clear;
	wire [3:0]  ack_vec;
	wire        down_counting;

	// ----------------------------------------------------------------
	// waveform mode decode
	// ----------------------------------------------------------------
	assign cap_top_mode = (WAVEFORM_MODE_FIELD == `MODE_PFC_CAPTURE) ||
			      (WAVEFORM_MODE_FIELD == `MODE_PC_CAPTURE) ||
			      (WAVEFORM_MODE_FIELD == `MODE_CLEAR_CAP) ||
			      (WAVEFORM_MODE_FIELD == `MODE_FAST_CAPTURE);
	assign CAPTURE_IS_TOP = cap_top_mode;
	assign COUNTER_TOP    = top_value;

	always @* begin
		case (WAVEFORM_MODE_FIELD)
		`MODE_PC8, `MODE_FAST8:   top_value = `TOP_8BIT;
		`MODE_PC9, `MODE_FAST9:   top_value = `TOP_9BIT;
		`MODE_PC10, `MODE_FAST10: top_value = `TOP_10BIT;
		`MODE_CLEAR_A, `MODE_PFC_A, `MODE_PC_A, `MODE_FAST_A:
			top_value = COMPARE_VALUE_A;
		`MODE_PFC_CAPTURE, `MODE_PC_CAPTURE, `MODE_CLEAR_CAP, `MODE_FAST_CAPTURE:
			top_value = capture_value;
		default:                  top_value = `COUNT_MAX;
		endcase
	end

	// ----------------------------------------------------------------
	// event source synchronisers
	// ----------------------------------------------------------------
	// a level change is accepted once the second and third stages agree, so the
	// first stage never feeds logic and a one-cycle glitch is dropped
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_sync  <= 3'h0;
			cmp_sync  <= 3'h0;
			pin_level <= 1'b0;
			cmp_level <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], CAPTURE_INPUT_PIN};
			cmp_sync <= {cmp_sync[1:0], COMPARATOR_OUT};
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
			if (cmp_sync[1] == cmp_sync[2])
				cmp_level <= cmp_sync[2];
		end
	end

	assign src_new  = CAPTURE_FROM_COMPARATOR ?
			  ((cmp_sync[1] == cmp_sync[2]) ? cmp_sync[2] : cmp_level) :
			  ((pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level);
	assign src_prev = CAPTURE_FROM_COMPARATOR ? cmp_level : pin_level;
	assign src_level = src_new;

	// pin is ignored entirely while the capture register is the top value
	assign capture_event = !cap_top_mode && (src_level != src_prev) &&
			       (src_level == CAPTURE_EDGE_RISING);

	// ----------------------------------------------------------------
	// counter events
	// ----------------------------------------------------------------
	// direction is inferred from the previous count value; phase-correct modes
	// turn at top and bottom, so a decrease marks the down slope
	assign down_counting = count_prev_valid && (WIDE_COUNTER < count_prev);
	assign reached_top   = TIMER_TICK && (WIDE_COUNTER == top_value);

	function wrap_for_mode;
		input [3:0]  mode;
		input [15:0] count;
		input        tick;
		input [15:0] top;
		begin
			case (mode)
			`MODE_NORMAL, `MODE_CLEAR_A, `MODE_CLEAR_CAP:
				wrap_for_mode = tick && (count == `COUNT_MAX);
			`MODE_FAST8, `MODE_FAST9, `MODE_FAST10, `MODE_FAST_CAPTURE, `MODE_FAST_A:
				wrap_for_mode = tick && (count == top);
			`MODE_PC8, `MODE_PC9, `MODE_PC10, `MODE_PFC_CAPTURE,
			`MODE_PFC_A, `MODE_PC_CAPTURE, `MODE_PC_A:
				wrap_for_mode = tick && (count == `COUNT_BOTTOM);
			default:
				wrap_for_mode = 1'b0;
			endcase
		end
	endfunction

	assign wrap_event = wrap_for_mode(WAVEFORM_MODE_FIELD, WIDE_COUNTER,
					  TIMER_TICK, top_value);

	// a match is registered and flagged one timer tick later; a counter write
	// blocks the match, and the forced strobes are deliberately not looked at
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			match_a_seen     <= 1'b0;
			match_b_seen     <= 1'b0;
			count_prev       <= `CAPTURE_RESET;
			count_prev_valid <= 1'b0;
		end else begin
			if (TIMER_TICK) begin
				match_a_seen <= !COUNTER_WRITE &&
						(WIDE_COUNTER == COMPARE_VALUE_A);
				match_b_seen <= !COUNTER_WRITE &&
						(WIDE_COUNTER == COMPARE_VALUE_B);
				count_prev       <= WIDE_COUNTER;
				count_prev_valid <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	assign ack_vec = {ACK_CAPTURE, ACK_MATCH_A, ACK_MATCH_B, ACK_WRAP};

	assign flag_set = {2'b00,
			   capture_event | (cap_top_mode & reached_top),
			   TIMER_TICK & match_a_seen,
			   TIMER_TICK & match_b_seen,
			   wrap_event,
			   2'b00};

	// software clears by writing ones; zeros are no-ops
	assign flag_clear = ({8{WR && (ADDR == `ADDR_IRQ_FLAGS)}} & WDATA) |
			    {2'b00, ack_vec, 2'b00};

	always @* begin
		// a set arriving with its clear wins so no event is lost
		next_flags = ((timer_irq_flags & ~flag_clear) | flag_set) & `TIMER_BITS_MASK;
		next_capture = capture_value;
		if (capture_event)
			next_capture = WIDE_COUNTER;
		else if (WR && (ADDR == `ADDR_CAPTURE_LOW))
			next_capture = {temp_high, WDATA};
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			capture_value         <= `CAPTURE_RESET;
			temp_high             <= `BYTE_RESET;
			timer_irq_enable_mask <= `BYTE_RESET;
			timer_irq_flags       <= `BYTE_RESET;
			RDATA                 <= `BYTE_RESET;
		end else begin
			capture_value   <= next_capture;
			timer_irq_flags <= next_flags;
			if (WR && (ADDR == `ADDR_IRQ_MASK))
				timer_irq_enable_mask <= WDATA & `TIMER_BITS_MASK;
			// shared high byte: high writes stage here, low reads fill it
			if (WR && ((ADDR == `ADDR_CAPTURE_HIGH) || (ADDR == `ADDR_TEMP_HIGH)))
				temp_high <= WDATA;
			else if (RD && (ADDR == `ADDR_CAPTURE_LOW))
				temp_high <= capture_value[15:8];
			RDATA <= `BYTE_RESET;
			if (RD) begin
				case (ADDR)
				`ADDR_CAPTURE_LOW:  RDATA <= capture_value[7:0];
				`ADDR_CAPTURE_HIGH: RDATA <= temp_high;
				`ADDR_IRQ_MASK:     RDATA <= timer_irq_enable_mask;
				`ADDR_IRQ_FLAGS:    RDATA <= timer_irq_flags;
				`ADDR_TEMP_HIGH:    RDATA <= temp_high;
				default:            RDATA <= `BYTE_RESET;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt requests
	// ----------------------------------------------------------------
	assign IRQ_CAPTURE = GLOBAL_IRQ_ENABLE && timer_irq_enable_mask[`BIT_CAPTURE] &&
			     timer_irq_flags[`BIT_CAPTURE];
	assign IRQ_MATCH_A = GLOBAL_IRQ_ENABLE && timer_irq_enable_mask[`BIT_MATCH_A] &&
			     timer_irq_flags[`BIT_MATCH_A];
	assign IRQ_MATCH_B = GLOBAL_IRQ_ENABLE && timer_irq_enable_mask[`BIT_MATCH_B] &&
			     timer_irq_flags[`BIT_MATCH_B];
	assign IRQ_WRAP    = GLOBAL_IRQ_ENABLE && timer_irq_enable_mask[`BIT_WRAP] &&
			     timer_irq_flags[`BIT_WRAP];

endmodule // timer16_capture_irq_flags

// *** bench/timer16_capture_irq_flags_checker.sv ***
// port-level assertions for the capture register and timer flag block
// bound from the testbench top onto the design; single clock domain
`timescale 1ns/100ps
module timer16_capture_irq_flags_checker (
	input wire        CLK,
	input wire        RST_B,
	input wire [2:0]  ADDR,
	input wire        WR,
	input wire        RD,
	input wire [7:0]  RDATA,
	input wire [3:0]  WAVEFORM_MODE_FIELD,
	input wire        GLOBAL_IRQ_ENABLE,
	input wire        ACK_WRAP,
	input wire        IRQ_CAPTURE,
	input wire        IRQ_MATCH_A,
	input wire        IRQ_MATCH_B,
	input wire        IRQ_WRAP,
	input wire [15:0] COUNTER_TOP,
	input wire        CAPTURE_IS_TOP
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	// ----------------------------------------------------------------
	// requests need the global enable
	// ----------------------------------------------------------------
	AST_IRQ_CAP: assert property (IRQ_CAPTURE |-> GLOBAL_IRQ_ENABLE)
		else $error("capture request while globally disabled");
	AST_IRQ_MATCH_A: assert property (IRQ_MATCH_A |-> GLOBAL_IRQ_ENABLE)
		else $error("match a request while globally disabled");
	AST_IRQ_MATCH_B: assert property (IRQ_MATCH_B |-> GLOBAL_IRQ_ENABLE)
		else $error("match b request while globally disabled");
	AST_IRQ_WRAP: assert property (IRQ_WRAP |-> GLOBAL_IRQ_ENABLE)
		else $error("wrap request while globally disabled");
	// a wrap request only drops on a vector ack, any register write or global disable
	AST_WRAP_DROP: assert property ($fell(IRQ_WRAP) |-> $past(ACK_WRAP) || $past(WR) || !GLOBAL_IRQ_ENABLE)
		else $error("wrap request dropped without cause");

	// ----------------------------------------------------------------
	// top selection and reserved bits
	// ----------------------------------------------------------------
	AST_TOP_SEL: assert property (CAPTURE_IS_TOP == (WAVEFORM_MODE_FIELD[3] && !WAVEFORM_MODE_FIELD[0]))
		else $error("capture top select wrong for mode");
	AST_TOP_NORMAL: assert property (WAVEFORM_MODE_FIELD == 4'h0 |-> COUNTER_TOP == 16'hFFFF)
		else $error("normal mode top not full scale");
	AST_RSVD: assert property ($past(RD) && ($past(ADDR) >> 1) == 3'h1 |-> (RDATA & 8'hC3) == 8'h00)
		else $error("reserved mask or flag bit read nonzero");

	CVR_MATCH_A: cover property (IRQ_MATCH_A);
	CVR_CAPTURE: cover property (IRQ_CAPTURE && !CAPTURE_IS_TOP);
	CVR_TOP_FLAG: cover property (IRQ_CAPTURE && CAPTURE_IS_TOP);
endmodule // timer16_capture_irq_flags_checker

// *** bench/timer16_capture_irq_flags_tb.sv ***
// self-checking bench for the capture register and timer flag block
// drives every design port itself on a 20 MHz clock; no far-side model
`timescale 1ns/100ps
module timer16_capture_irq_flags_tb;
	reg         clk, rst_b, we, re, tick, cwr, fa, fb, edge_r, from_cmp, pin, cmp, gie;
	reg         ack_c, ack_a, ack_b, ack_w;
	reg  [2:0]  addr;
	reg  [7:0]  wdata;
	reg  [3:0]  mode;
	reg  [15:0] cnt, cmp_a, cmp_b;
	wire [7:0]  rdata;
	wire        irq_c, irq_a, irq_b, irq_w, cap_top;
	wire [15:0] top;
	integer     failures, num_checks, i;

	always #25 clk = ~clk;

	timer16_capture_irq_flags dut (
		.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(we), .RD(re),
		.RDATA(rdata), .WIDE_COUNTER(cnt), .TIMER_TICK(tick), .WAVEFORM_MODE_FIELD(mode),
		.COMPARE_VALUE_A(cmp_a), .COMPARE_VALUE_B(cmp_b), .COUNTER_WRITE(cwr),
		.FORCE_MATCH_A_STROBE(fa), .FORCE_MATCH_B_STROBE(fb), .CAPTURE_EDGE_RISING(edge_r),
		.CAPTURE_FROM_COMPARATOR(from_cmp), .CAPTURE_INPUT_PIN(pin), .COMPARATOR_OUT(cmp),
		.GLOBAL_IRQ_ENABLE(gie), .ACK_CAPTURE(ack_c), .ACK_MATCH_A(ack_a),
		.ACK_MATCH_B(ack_b), .ACK_WRAP(ack_w), .IRQ_CAPTURE(irq_c), .IRQ_MATCH_A(irq_a),
		.IRQ_MATCH_B(irq_b), .IRQ_WRAP(irq_w), .COUNTER_TOP(top), .CAPTURE_IS_TOP(cap_top)
	);

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task chk(input [15:0] got, input [15:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task wr_reg(input [2:0] a, input [7:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	end
	endtask

	// read data stand only in the cycle after the strobe
	task rd_reg(input [2:0] a, input [7:0] exp);
	begin
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk({8'h00, rdata}, {8'h00, exp});
	end
	endtask

	// one counter step with the timer clock enable high
	task tk(input [15:0] c);
	begin
		@(posedge clk);
		cnt <= c;
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
	end
	endtask

	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask

	initial begin
		#(50 * 3000);
		failures = failures + 1;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		{clk, rst_b, we, re, tick, cwr, fa, fb, from_cmp, pin, cmp, ack_c, ack_a, ack_b, ack_w} = 0;
		{addr, wdata, mode, cnt} = 0;
		{edge_r, gie} = 2'b11;
		cmp_a = 16'h0010;
		cmp_b = 16'h0020;
		failures = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 4; i = i + 1) rd_reg(i, 8'h00);
		wr_reg(3'h2, 8'hFF);
		rd_reg(3'h2, 8'h3C);
		$display("test 1 done");
		@(posedge clk);
		fa <= 1'b1;
		fb <= 1'b1;
		tk(16'h0005);
		fa <= 1'b0;
		fb <= 1'b0;
		tk(16'h0006);
		rd_reg(3'h3, 8'h00);
		tk(16'h000F);
		tk(16'h0010);
		tk(16'h0011);
		rd_reg(3'h3, 8'h10);
		chk(irq_a, 1'b1);
		wr_reg(3'h3, 8'h00);
		rd_reg(3'h3, 8'h10);
		wr_reg(3'h3, 8'h10);
		rd_reg(3'h3, 8'h00);
		tk(16'h0020);
		tk(16'h0021);
		rd_reg(3'h3, 8'h08);
		chk(irq_b, 1'b1);
		@(posedge clk);
		ack_b <= 1'b1;
		@(posedge clk);
		ack_b <= 1'b0;
		rd_reg(3'h3, 8'h00);
		$display("test 2 done");
		tk(16'hFFFF);
		tk(16'h0000);
		rd_reg(3'h3, 8'h04);
		chk(irq_w, 1'b1);
		@(posedge clk);
		gie <= 1'b0;
		#1 chk(irq_w, 1'b0);
		@(posedge clk);
		gie <= 1'b1;
		ack_w <= 1'b1;
		@(posedge clk);
		ack_w <= 1'b0;
		rd_reg(3'h3, 8'h00);
		$display("test 3 done");
		// counter held still so the captured value does not depend on latency
		@(posedge clk);
		cnt <= 16'h1234;
		pin <= 1'b1;
		repeat (6) @(posedge clk);
		rd_reg(3'h3, 8'h20);
		chk(irq_c, 1'b1);
		rd_reg(3'h0, 8'h34);
		rd_reg(3'h1, 8'h12);
		wr_reg(3'h3, 8'h20);
		rd_reg(3'h3, 8'h00);
		@(posedge clk);
		cnt <= 16'h5678;
		from_cmp <= 1'b1;
		cmp <= 1'b1;
		repeat (6) @(posedge clk);
		rd_reg(3'h0, 8'h78);
		rd_reg(3'h1, 8'h56);
		wr_reg(3'h3, 8'h3C);
		$display("test 4 done");
		@(posedge clk);
		from_cmp <= 1'b0;
		pin <= 1'b0;
		mode <= 4'hC;
		wr_reg(3'h1, 8'h00);
		wr_reg(3'h0, 8'h40);
		// let the write land before looking at the top value it feeds
		#1 chk(cap_top, 1'b1);
		chk(top, 16'h0040);
		@(posedge clk);
		pin <= 1'b1;
		repeat (6) @(posedge clk);
		rd_reg(3'h0, 8'h40);
		rd_reg(3'h3, 8'h00);
		tk(16'h0040);
		rd_reg(3'h3, 8'h20);
		$display("test 5 done");
		tally_and_finish;
	end
endmodule // timer16_capture_irq_flags_tb

bind timer16_capture_irq_flags timer16_capture_irq_flags_checker chk_i (
	.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
	.WAVEFORM_MODE_FIELD(WAVEFORM_MODE_FIELD), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
	.ACK_WRAP(ACK_WRAP), .IRQ_CAPTURE(IRQ_CAPTURE), .IRQ_MATCH_A(IRQ_MATCH_A),
	.IRQ_MATCH_B(IRQ_MATCH_B), .IRQ_WRAP(IRQ_WRAP), .COUNTER_TOP(COUNTER_TOP),
	.CAPTURE_IS_TOP(CAPTURE_IS_TOP)
);
